// ===== common/ipc_event_pkg.sv
package ipc_event_pkg;
  // channels per direction and how many of them raise interrupts
  localparam int NUM_CHAN = 32;
  localparam int IRQ_CHAN = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // per-port register map, byte offsets of aligned 32-bit words
  localparam logic [7:0] OFS_OUT_SET = 8'h00;
  localparam logic [7:0] OFS_OUT_FLAG = 8'h04;
  localparam logic [7:0] OFS_IN_ACK = 8'h08;
  localparam logic [7:0] OFS_IN_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // reset values
  localparam logic [31:0] FLAG_RESET = 32'h00000000;
  localparam logic [3:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
endpackage

// ===== logic/event_direction.sv
`timescale 1ns/1ps
module event_direction #(
  parameter int NUM_CHAN = 32
) (
  input wire logic clock, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic set_wr, // sender writes the set register
  input wire logic [NUM_CHAN-1:0] set_data, // ones start events
  input wire logic ack_wr, // receiver writes the acknowledge register
  input wire logic [NUM_CHAN-1:0] ack_data, // ones clear events
  output logic [NUM_CHAN-1:0] flag, // shared flag/status register
  output logic [NUM_CHAN-1:0] new_event // pulse: channel just raised
);
  wire [NUM_CHAN-1:0] set_bits;
  wire [NUM_CHAN-1:0] ack_bits;
  wire [NUM_CHAN-1:0] next_flag;

  // zero bits of either write leave their channel alone
  assign set_bits = set_wr ? set_data : '0;
  assign ack_bits = ack_wr ? ack_data : '0;
  // set beats acknowledge when both land in one cycle
  assign next_flag = (flag & ~ack_bits) | set_bits;
  assign new_event = set_bits & ~flag;

  // one physical register serves both views
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      flag <= ipc_event_pkg::FLAG_RESET;
    end else begin
      flag <= next_flag;
    end
  end
endmodule

// ===== logic/ipc_event_handshake.sv
`timescale 1ns/1ps
module ipc_event_handshake #(
  parameter int NUM_CHAN = ipc_event_pkg::NUM_CHAN,
  parameter int IRQ_CHAN = ipc_event_pkg::IRQ_CHAN
) (
  input wire logic clock, // 250 MHz system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [7:0] m_addr, // master port byte address
  input wire logic [31:0] m_wdata, // master port write data
  input wire logic m_wr, // master port write strobe
  input wire logic m_rd, // master port read strobe
  output logic [31:0] m_rdata, // master port read data, next cycle
  output logic m_irq, // master summary interrupt, level
  output logic [IRQ_CHAN-1:0] c2m_chan_irq, // channel irqs to master
  input wire logic [7:0] c_addr, // control port byte address
  input wire logic [31:0] c_wdata, // control port write data
  input wire logic c_wr, // control port write strobe
  input wire logic c_rd, // control port read strobe
  output logic [31:0] c_rdata, // control port read data, next cycle
  output logic c_irq, // control summary interrupt, level
  output logic [IRQ_CHAN-1:0] m2c_chan_irq // channel irqs to control
);
  logic [NUM_CHAN-1:0] m2c_flag;
  logic [NUM_CHAN-1:0] c2m_flag;
  logic [NUM_CHAN-1:0] m2c_new;
  logic [NUM_CHAN-1:0] c2m_new;
  logic [IRQ_CHAN-1:0] m_irq_status;
  logic [IRQ_CHAN-1:0] m_irq_mask;
  logic [IRQ_CHAN-1:0] c_irq_status;
  logic [IRQ_CHAN-1:0] c_irq_mask;

  // master port decode: it sends on m2c and receives on c2m
  wire m_hit_set = m_addr == ipc_event_pkg::OFS_OUT_SET;
  wire m_hit_flag = m_addr == ipc_event_pkg::OFS_OUT_FLAG;
  wire m_hit_ack = m_addr == ipc_event_pkg::OFS_IN_ACK;
  wire m_hit_sts = m_addr == ipc_event_pkg::OFS_IN_STATUS;
  wire m_hit_istat = m_addr == ipc_event_pkg::OFS_IRQ_STATUS;
  wire m_hit_imask = m_addr == ipc_event_pkg::OFS_IRQ_MASK;
  wire m2c_set_wr = m_wr && m_hit_set;
  wire c2m_ack_wr = m_wr && m_hit_ack;
  wire m_istat_wr = m_wr && m_hit_istat;
  wire m_imask_wr = m_wr && m_hit_imask;

  // control port decode: it sends on c2m and receives on m2c
  wire c_hit_set = c_addr == ipc_event_pkg::OFS_OUT_SET;
  wire c_hit_flag = c_addr == ipc_event_pkg::OFS_OUT_FLAG;
  wire c_hit_ack = c_addr == ipc_event_pkg::OFS_IN_ACK;
  wire c_hit_sts = c_addr == ipc_event_pkg::OFS_IN_STATUS;
  wire c_hit_istat = c_addr == ipc_event_pkg::OFS_IRQ_STATUS;
  wire c_hit_imask = c_addr == ipc_event_pkg::OFS_IRQ_MASK;
  wire c2m_set_wr = c_wr && c_hit_set;
  wire m2c_ack_wr = c_wr && c_hit_ack;
  wire c_istat_wr = c_wr && c_hit_istat;
  wire c_imask_wr = c_wr && c_hit_imask;

  // separate register sets, one instance per direction
  event_direction #(
    .NUM_CHAN(NUM_CHAN)
  ) u_m2c (
    .clock(clock),
    .rst_b(rst_b),
    .set_wr(m2c_set_wr),
    .set_data(m_wdata[NUM_CHAN-1:0]),
    .ack_wr(m2c_ack_wr),
    .ack_data(c_wdata[NUM_CHAN-1:0]),
    .flag(m2c_flag),
    .new_event(m2c_new)
  );

  // same handshake, processors swapped
  event_direction #(
    .NUM_CHAN(NUM_CHAN)
  ) u_c2m (
    .clock(clock),
    .rst_b(rst_b),
    .set_wr(c2m_set_wr),
    .set_data(c_wdata[NUM_CHAN-1:0]),
    .ack_wr(c2m_ack_wr),
    .ack_data(m_wdata[NUM_CHAN-1:0]),
    .flag(c2m_flag),
    .new_event(c2m_new)
  );

  // channel interrupts follow the flag, so an ack removes them
  assign m2c_chan_irq = m2c_flag[IRQ_CHAN-1:0];
  assign c2m_chan_irq = c2m_flag[IRQ_CHAN-1:0];

  // sticky event capture for the receiver; new events beat w1c
  wire [IRQ_CHAN-1:0] m_istat_clr =
    m_istat_wr ? m_wdata[IRQ_CHAN-1:0] : '0;
  wire [IRQ_CHAN-1:0] c_istat_clr =
    c_istat_wr ? c_wdata[IRQ_CHAN-1:0] : '0;
  wire [IRQ_CHAN-1:0] next_m_irq_status =
    (m_irq_status & ~m_istat_clr) | c2m_new[IRQ_CHAN-1:0];
  wire [IRQ_CHAN-1:0] next_c_irq_status =
    (c_irq_status & ~c_istat_clr) | m2c_new[IRQ_CHAN-1:0];
  wire [IRQ_CHAN-1:0] next_m_irq_mask =
    m_imask_wr ? m_wdata[IRQ_CHAN-1:0] : m_irq_mask;
  wire [IRQ_CHAN-1:0] next_c_irq_mask =
    c_imask_wr ? c_wdata[IRQ_CHAN-1:0] : c_irq_mask;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      m_irq_status <= ipc_event_pkg::IRQ_STATUS_RESET;
      c_irq_status <= ipc_event_pkg::IRQ_STATUS_RESET;
      m_irq_mask <= ipc_event_pkg::IRQ_MASK_RESET;
      c_irq_mask <= ipc_event_pkg::IRQ_MASK_RESET;
    end else begin
      m_irq_status <= next_m_irq_status;
      c_irq_status <= next_c_irq_status;
      m_irq_mask <= next_m_irq_mask;
      c_irq_mask <= next_c_irq_mask;
    end
  end

  assign m_irq = |(m_irq_status & m_irq_mask);
  assign c_irq = |(c_irq_status & c_irq_mask);

  // read muxes; write-only and unmapped words read as zero
  wire [31:0] m2c_flag_w = 32'(m2c_flag);
  wire [31:0] c2m_flag_w = 32'(c2m_flag);
  wire [31:0] m_istat_w = 32'(m_irq_status);
  wire [31:0] m_imask_w = 32'(m_irq_mask);
  wire [31:0] c_istat_w = 32'(c_irq_status);
  wire [31:0] c_imask_w = 32'(c_irq_mask);

  // sender sees its flag view, receiver the status view
  wire [31:0] m_read_word =
    m_hit_flag ? m2c_flag_w :
    m_hit_sts ? c2m_flag_w :
    m_hit_istat ? m_istat_w :
    m_hit_imask ? m_imask_w :
    ipc_event_pkg::READ_ZERO;
  wire [31:0] c_read_word =
    c_hit_flag ? c2m_flag_w :
    c_hit_sts ? m2c_flag_w :
    c_hit_istat ? c_istat_w :
    c_hit_imask ? c_imask_w :
    ipc_event_pkg::READ_ZERO;
  wire [31:0] next_m_rdata = m_rd ? m_read_word : ipc_event_pkg::READ_ZERO;
  wire [31:0] next_c_rdata = c_rd ? c_read_word : ipc_event_pkg::READ_ZERO;

  // data stand only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      m_rdata <= ipc_event_pkg::READ_ZERO;
      c_rdata <= ipc_event_pkg::READ_ZERO;
    end else begin
      m_rdata <= next_m_rdata;
      c_rdata <= next_c_rdata;
    end
  end
endmodule

// ===== test/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
  input wire logic clock, // system clock
  output logic [7:0] addr = 8'h00, // byte address
  output logic [31:0] wdata = 32'h00000000, // write data
  output logic wr = 1'b0, // write strobe
  output logic rd = 1'b0, // read strobe
  input wire logic [31:0] rdata); // read data
  task automatic put(input logic [7:0] a, input logic [31:0] d);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clock) {addr, wdata, wr} <= {~a, ~d, 1'b0};
    @(posedge clock);
  endtask
  task automatic get(input logic [7:0] a, output logic [31:0] d);
    {addr, rd} <= {a, 1'b1};
    @(posedge clock) {addr, rd} <= {~a, 1'b0};
    // data stand only in the cycle after the strobe, take them at its edge
    @(posedge clock) d = rdata;
  endtask
endmodule

// ===== test/ipc_event_monitor.sv
`timescale 1ns/1ps
module ipc_event_monitor #(parameter int IRQ_CHAN = 4) (
  input wire logic clock, // clock
  input wire logic rst_b, // reset
  input wire logic [7:0] m_addr, // addr
  input wire logic [31:0] m_wdata, // data
  input wire logic m_wr, // write
  input wire logic [IRQ_CHAN-1:0] c2m_chan_irq, // to master
  input wire logic [7:0] c_addr, // addr
  input wire logic [31:0] c_wdata, // data
  input wire logic c_wr, // write
  input wire logic [IRQ_CHAN-1:0] m2c_chan_irq); // to control
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  wire ms = m_wr && m_addr == ipc_event_pkg::OFS_OUT_SET;
  wire ma = m_wr && m_addr == ipc_event_pkg::OFS_IN_ACK;
  wire cs = c_wr && c_addr == ipc_event_pkg::OFS_OUT_SET;
  wire ca = c_wr && c_addr == ipc_event_pkg::OFS_IN_ACK;
  wire [IRQ_CHAN-1:0] mw = m_wdata[IRQ_CHAN-1:0], cw = c_wdata[IRQ_CHAN-1:0];
  reset_clear_a: assert property (disable iff (1'b0) !rst_b |=>
    !m2c_chan_irq && !c2m_chan_irq) else $error("irq after reset");
  m2c_set_a: assert property (ms && !ca |=>
    m2c_chan_irq == ($past(m2c_chan_irq) | $past(mw))) else $error("set");
  c2m_set_a: assert property (cs && !ma |=>
    c2m_chan_irq == ($past(c2m_chan_irq) | $past(cw))) else $error("set");
  m2c_ack_a: assert property (ca && !ms |=>
    m2c_chan_irq == ($past(m2c_chan_irq) & ~$past(cw))) else $error("ack");
  c2m_ack_a: assert property (ma && !cs |=>
    c2m_chan_irq == ($past(c2m_chan_irq) & ~$past(mw))) else $error("ack");
  m2c_hold_a: assert property (!ms && !ca |=>
    $stable(m2c_chan_irq)) else $error("m2c moved");
  c2m_hold_a: assert property (!cs && !ma |=>
    $stable(c2m_chan_irq)) else $error("c2m moved");
  c2m_cause_a: assert property ($past(rst_b) &&
    $changed(c2m_chan_irq) |-> $past(cs) || $past(ma)) else $error("cause");
  cover property (ms ##[1:9] ca);
  cover property (cs ##[1:9] ma);
  cover property (ma ##1 !c2m_chan_irq);
endmodule
bind ipc_event_handshake ipc_event_monitor #(.IRQ_CHAN(IRQ_CHAN)) mon (
  .clock(clock),
  .rst_b(rst_b),
  .m_addr(m_addr),
  .m_wdata(m_wdata),
  .m_wr(m_wr),
  .c2m_chan_irq(c2m_chan_irq),
  .c_addr(c_addr),
  .c_wdata(c_wdata),
  .c_wr(c_wr),
  .m2c_chan_irq(m2c_chan_irq)
);

// ===== test/ipc_event_handshake_tb.sv
`timescale 1ns/1ps
module ipc_event_handshake_tb;
  logic clock = 1'b0, rst_b = 1'b0, m_wr, m_rd, c_wr, c_rd, m_irq, c_irq;
  logic [7:0] m_addr, c_addr;
  logic [31:0] m_wdata, c_wdata, m_rdata, c_rdata, d;
  logic [3:0] m2c_chan_irq, c2m_chan_irq;
  int n_errors = 0, samples_checked = 0;
  initial forever #2 clock = ~clock;
  wire [31:0] irq_view = {20'h0, m2c_chan_irq, c2m_chan_irq, 2'b00, m_irq,
    c_irq};
  cpu_model mp (.clock(clock), .addr(m_addr), .wdata(m_wdata), .wr(m_wr),
    .rd(m_rd), .rdata(m_rdata));
  cpu_model cp (.clock(clock), .addr(c_addr), .wdata(c_wdata), .wr(c_wr),
    .rd(c_rd), .rdata(c_rdata));
  ipc_event_handshake dut (
    .clock(clock), .rst_b(rst_b),
    .m_addr(m_addr), .m_wdata(m_wdata), .m_wr(m_wr), .m_rd(m_rd),
    .m_rdata(m_rdata), .m_irq(m_irq), .c2m_chan_irq(c2m_chan_irq),
    .c_addr(c_addr), .c_wdata(c_wdata), .c_wr(c_wr), .c_rd(c_rd),
    .c_rdata(c_rdata), .c_irq(c_irq), .m2c_chan_irq(m2c_chan_irq)
  );
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) $display("[ERR] %0t exp %h got %h", $time, e, g);
    if (g !== e) n_errors++;
  endtask
  task automatic final_report;
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic t_m2c;
    mp.get(8'h04, d);
    chk(32'h00000000, d);
    mp.put(8'h00, 32'h80000005);
    cp.get(8'h0c, d);
    chk(32'h80000005, d);
    cp.put(8'h08, 32'h00000004);
    mp.get(8'h04, d);
    chk(32'h80000001, d);
  endtask
  task automatic t_c2m_irq;
    mp.put(8'h14, 32'h00000008);
    cp.put(8'h00, 32'h0000000a);
    chk(32'h00000015, {27'h0, c2m_chan_irq, m_irq});
    mp.put(8'h08, 32'h0000000a);
    mp.put(8'h10, 32'h00000008);
    chk(32'h00000000, {27'h0, c2m_chan_irq, m_irq});
    mp.get(8'h20, d);
    chk(32'h00000000, d);
  endtask
  task automatic t_c_irq;
    chk(32'h00000002, {27'h0, m2c_chan_irq, c_irq});
    cp.get(8'h10, d);
    chk(32'h00000005, d);
    cp.put(8'h14, 32'h00000001);
    cp.get(8'h14, d);
    chk(32'h00000001, d);
    chk(32'h00000003, {27'h0, m2c_chan_irq, c_irq});
    cp.put(8'h08, 32'h80000001);
    chk(32'h00000001, {27'h0, m2c_chan_irq, c_irq});
    cp.put(8'h10, 32'h00000005);
    chk(32'h00000000, {27'h0, m2c_chan_irq, c_irq});
    mp.get(8'h04, d);
    chk(32'h00000000, d);
  endtask
  task automatic t_reset;
    mp.put(8'h00, 32'h0000000f);
    cp.put(8'h00, 32'h00000003);
    mp.put(8'h14, 32'h0000000f);
    chk(32'h00000f33, irq_view);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    chk(32'h00000000, irq_view);
    cp.get(8'h0c, d);
    chk(32'h00000000, d);
    mp.get(8'h14, d);
    chk(32'h00000000, d);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    t_m2c;
    t_c2m_irq;
    t_c_irq;
    t_reset;
    final_report;
  end
endmodule
